/* File: ssp_defines.svh */
// ssp_defines.svh: constants for the synchronous serial port (ssp_core, ssp_prescale)
// assumes: included by bare name; the core runs on the module clock (oscillator / 4)
// Functional notes
// R1: 8 or 16 clocks, shift out and in
// R2: completion sets done flag; irq if enabled
// R3: finished word moves into receive buffer
// R4: full receive buffer: flag overflow, drop word
// R5: overflow freezes port until buffer read; code stays frozen until OVF_CLR_I clears the flag
// R6: pending transmit word loads after completion
// R7: one buffer port: write tx, read rx
// R8: master drives clock; slave follows clock
// R9: master starts when buffer is written
// R10: master done flag at last bit middle
// R11: slave done when last bit latched
// R12: select low enables; high disables output
// R13: clock divided by primary, then secondary
// R14: edge bit picks output change edge
// R15: polarity bit sets clock idle level
// R16: control bit 10 picks 16 or 8
// R17: width change resets the port logic
// R18: send bit 7 or 15, receive bit 0
// R19: output disable bit frees data pin
// R20: framed mode turns select into sync
// R21: direction bit: generate or receive sync
// R22: sync one clock high, data follows
// R23: select release resets counters and state
// R24: transmit full and receive full flags
// R25: software clears overflow after reading buffer
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// word lengths in serial clocks
`define SSP_W8         5'h08
`define SSP_W16        5'h10
// received word masks
`define SSP_MASK8      16'h00ff
`define SSP_MASK16     16'hffff
// primary prescale factors for field values 0..3
`define SSP_PRI_DIV_0  10'h040
`define SSP_PRI_DIV_1  10'h010
`define SSP_PRI_DIV_2  10'h004
`define SSP_PRI_DIV_3  10'h001
// secondary factor is this base minus the field value
`define SSP_SEC_BASE   4'h8
// prescale counter width
`define SSP_DIV_W      10

`endif

/* File: ssp_pkg.sv */
// ssp_pkg.sv: types of the synchronous serial port
// assumes: nothing beyond ssp_defines.svh
package ssp_pkg;

  // control word, bit 10 is the word width select
  typedef struct packed {
    logic       rsv15;
    logic       framed_mode_enable;
    logic       frame_sync_direction;  // 1: sync pulse is an input
    logic       rsv12;
    logic       out_pin_disable;
    logic       word_width_select;     // 1: 16-bit words
    logic       rsv9;
    logic       clock_edge_select;     // 1: data changes active to idle
    logic       select_control_enable;
    logic       clock_idle_polarity;
    logic       master_mode;
    logic [2:0] secondary_prescale;
    logic [1:0] primary_prescale;
  } ssp_ctrl_t;

  // status flags
  typedef struct packed {
    logic rx_overflow_flag;
    logic transfer_done_flag;
    logic tx_full;
    logic rx_full;
  } ssp_stat_t;

  // sequencer states
  typedef enum logic [1:0] {
    SSP_IDLE = 2'h0,
    SSP_SYNC = 2'h1,
    SSP_DATA = 2'h2,
    SSP_TAIL = 2'h3
  } ssp_state_t;

endpackage

/* File: ssp_prescale.sv */
// ssp_prescale.sv: two-stage divider giving one tick per serial clock half period
// assumes: run held high only while the master clock should toggle
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_prescale (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [1:0] pri_i,
  input  wire logic [2:0] sec_i,
  // output
  output logic            tick_o
);
  logic [`SSP_DIV_W-1:0] cnt_reg;
  logic [`SSP_DIV_W-1:0] div;
  logic [`SSP_DIV_W-1:0] pri_div;
  logic [3:0]            sec_div;

  // R13: primary then secondary factor
  always_comb begin
    case (pri_i)
      2'h0:    pri_div = `SSP_PRI_DIV_0;
      2'h1:    pri_div = `SSP_PRI_DIV_1;
      2'h2:    pri_div = `SSP_PRI_DIV_2;
      default: pri_div = `SSP_PRI_DIV_3;
    endcase
    sec_div = 4'(`SSP_SEC_BASE - {1'h0, sec_i});
    div     = `SSP_DIV_W'(pri_div * sec_div);
  end

  // count to the divide value while running, restarts on each tick or when stopped
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i || tick_o) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= `SSP_DIV_W'(cnt_reg + 1'b1);
    end
  end

  assign tick_o = run_i && (cnt_reg == `SSP_DIV_W'(div - 1'b1));
endmodule // ssp_prescale
`default_nettype wire

/* File: ssp_core.sv */
// ssp_core.sv: synchronous serial port, master or slave, with double buffered data
// assumes: all pin inputs synchronous to CLK_I; software side drives strobes for one cycle
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_core (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  // configuration
  input  wire logic              PORT_EN_I,
  input  var  ssp_pkg::ssp_ctrl_t CTRL_I,
  input  wire logic              IRQ_EN_I,
  // shared buffer port and flag clears
  input  wire logic              BUF_WR_I,
  input  wire logic [15:0]       BUF_WDATA_I,
  input  wire logic              BUF_RD_I,
  input  wire logic              OVF_CLR_I,
  input  wire logic              DONE_CLR_I,
  // software side results
  output logic [15:0]            BUF_RDATA_O,
  output var  ssp_pkg::ssp_stat_t STAT_O,
  output logic                   IRQ_O,
  // shift clock pin
  input  wire logic              SCK_I,
  output logic                   SCK_O,
  output logic                   SCK_OE_N_O,
  // serial data pins
  input  wire logic              SDI_I,
  output logic                   SDO_O,
  output logic                   SDO_OE_N_O,
  // slave select / frame sync pin
  input  wire logic              SS_I,
  output logic                   SS_O,
  output logic                   SS_OE_N_O
);
  import ssp_pkg::*;

  ssp_ctrl_t   c;
  ssp_state_t  state_reg;
  logic [15:0] sr_reg;
  logic [15:0] tx_buf_reg;
  logic [15:0] rx_buf_reg;
  logic [15:0] word_in;
  logic [4:0]  bit_cnt_reg;
  logic [4:0]  word_len;
  logic        out_reg;
  logic        sck_reg;
  logic        sck_prev_reg;
  logic        fs_reg;
  logic        width_reg;
  logic        sync_cnt_reg;
  logic        tx_full_reg;
  logic        rx_full_reg;
  logic        ovf_reg;
  logic        done_reg;
  logic        tick;
  logic        ss_mode;
  logic        sel_hold;
  logic        port_hold;
  logic        gen_fs;
  logic        m_edge;
  logic        s_edge;
  logic        edge_ok;
  logic        to_active;
  logic        chg_edge;
  logic        shift_edge;
  logic        sample_edge;
  logic        start_ok;
  logic        load_evt;
  logic        done_evt;
  logic        sync_step;

  // R18: outgoing bit sits at 7 or 15
  function automatic logic msb_of(input logic [15:0] v, input logic w16);
    msb_of = w16 ? v[15] : v[7];
  endfunction

  // decodes of control and pins
  assign c         = CTRL_I;
  // R16: bit count from width select
  assign word_len  = c.word_width_select ? `SSP_W16 : `SSP_W8;
  assign ss_mode   = c.select_control_enable && !c.master_mode && !c.framed_mode_enable;
  // R12: select high holds the slave off
  assign sel_hold  = ss_mode && SS_I;
  // R17: width change resets the port
  assign port_hold = !PORT_EN_I || (c.word_width_select != width_reg) || sel_hold;
  // R21: direction picks generate or receive
  assign gen_fs    = c.framed_mode_enable && !c.frame_sync_direction;

  // R8: clock edges from own divider or pin
  assign m_edge     = c.master_mode && tick && (state_reg != SSP_IDLE)
                      && !(state_reg == SSP_TAIL && sck_reg == c.clock_idle_polarity);
  assign s_edge     = !c.master_mode && (SCK_I != sck_prev_reg);
  // R5: overflow ignores clock edges
  assign edge_ok    = (m_edge || s_edge) && !ovf_reg && !port_hold;
  assign to_active  = c.master_mode ? (sck_reg == c.clock_idle_polarity) : (SCK_I != c.clock_idle_polarity);
  // R14: edge select picks the output change edge
  assign chg_edge   = c.clock_edge_select ? !to_active : to_active;
  assign shift_edge = edge_ok && chg_edge;
  assign sample_edge = edge_ok && !chg_edge;

  // R9: master starts once a word is written
  assign start_ok  = (state_reg == SSP_IDLE) && !port_hold && !ovf_reg && (tx_full_reg || !c.master_mode);
  assign load_evt  = start_ok && tx_full_reg;
  // R10: master done at last sample, mid bit
  // R11: slave done as last bit is latched
  assign done_evt  = (state_reg == SSP_DATA) && sample_edge && (bit_cnt_reg == 5'(word_len - 5'h1));
  assign word_in   = {sr_reg[14:0], SDI_I} & (c.word_width_select ? `SSP_MASK16 : `SSP_MASK8);
  // R22: sync lasts one serial clock, two edges
  assign sync_step = edge_ok && (gen_fs || SS_I || sync_cnt_reg);

  // master clock divider
  ssp_prescale u_prescale (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .run_i  (c.master_mode && (state_reg != SSP_IDLE) && !port_hold),
    .pri_i  (c.primary_prescale),
    .sec_i  (c.secondary_prescale),
    .tick_o (tick)
  );

  // sequencer: idle, frame sync, data bits, clock return
  always_ff @(posedge CLK_I) begin
    // R23: select release clears counters and state
    if (!NRST_I || port_hold) begin
      state_reg    <= SSP_IDLE;
      bit_cnt_reg  <= 5'h0;
      sync_cnt_reg <= 1'h0;
      fs_reg       <= 1'h0;
    end else begin
      case (state_reg)
        SSP_IDLE: begin
          if (start_ok) begin
            // R20: framed mode goes through sync phase
            state_reg <= c.framed_mode_enable ? SSP_SYNC : SSP_DATA;
            fs_reg    <= gen_fs;
          end
        end
        SSP_SYNC: begin
          // R22: data starts after the sync clock
          if (sync_step) begin
            if (sync_cnt_reg) begin
              state_reg    <= SSP_DATA;
              sync_cnt_reg <= 1'h0;
              fs_reg       <= 1'h0;
            end else begin
              sync_cnt_reg <= 1'h1;
            end
          end
        end
        SSP_DATA: begin
          // R1: count 8 or 16 sampled bits
          if (sample_edge) begin
            if (done_evt) begin
              bit_cnt_reg <= 5'h0;
              state_reg   <= c.master_mode ? SSP_TAIL : SSP_IDLE;
            end else begin
              bit_cnt_reg <= 5'(bit_cnt_reg + 5'h1);
            end
          end
        end
        SSP_TAIL: begin
          if (!c.master_mode || sck_reg == c.clock_idle_polarity) begin
            state_reg <= SSP_IDLE;
          end
        end
        default: state_reg <= SSP_IDLE;
      endcase
    end
  end

  // shift register and output bit
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sr_reg  <= 16'h0000;
      out_reg <= 1'h0;
    end else if (load_evt) begin
      // R6: pending word enters the shift register
      sr_reg  <= tx_buf_reg;
      out_reg <= msb_of(tx_buf_reg, c.word_width_select);
    end else if (state_reg == SSP_DATA) begin
      // R18: receive into bit 0
      if (sample_edge) begin
        sr_reg <= {sr_reg[14:0], SDI_I};
      end
      if (shift_edge) begin
        out_reg <= msb_of(sr_reg, c.word_width_select);
      end
    end
  end

  // transmit holding buffer
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      tx_buf_reg  <= 16'h0000;
      tx_full_reg <= 1'h0;
    end else begin
      // R7: buffer write fills transmit side
      if (BUF_WR_I) begin
        tx_buf_reg <= BUF_WDATA_I;
      end
      // R24: transmit full, write wins over load
      if (BUF_WR_I) begin
        tx_full_reg <= 1'h1;
      end else if (load_evt) begin
        tx_full_reg <= 1'h0;
      end
    end
  end

  // receive holding buffer and overflow
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      rx_buf_reg  <= 16'h0000;
      rx_full_reg <= 1'h0;
      ovf_reg     <= 1'h0;
    end else begin
      // R3: completed word moves to receive buffer
      if (done_evt && !(rx_full_reg && !BUF_RD_I)) begin
        rx_buf_reg  <= word_in;
        rx_full_reg <= 1'h1;
      end else if (BUF_RD_I) begin
        // R24: read empties the receive buffer
        rx_full_reg <= 1'h0;
      end
      // R4: full buffer flags overflow, word lost
      if (done_evt && rx_full_reg && !BUF_RD_I) begin
        ovf_reg <= 1'h1;
      end else if (OVF_CLR_I) begin
        ovf_reg <= 1'h0;
      end
    end
  end

  // R2: sticky done flag, set wins over clear
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      done_reg <= 1'h0;
    end else if (done_evt) begin
      done_reg <= 1'h1;
    end else if (DONE_CLR_I) begin
      done_reg <= 1'h0;
    end
  end

  // clock pin level and history
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sck_reg      <= 1'h0;
      sck_prev_reg <= 1'h0;
      width_reg    <= 1'h0;
    end else begin
      sck_prev_reg <= SCK_I;
      width_reg    <= c.word_width_select;
      // R15: idle level from polarity bit
      if (port_hold || state_reg == SSP_IDLE) begin
        sck_reg <= c.clock_idle_polarity;
      end else if (m_edge) begin
        sck_reg <= !sck_reg;
      end
    end
  end

  // pin and software outputs
  assign BUF_RDATA_O = rx_buf_reg;
  assign STAT_O      = '{rx_overflow_flag: ovf_reg, transfer_done_flag: done_reg,
                         tx_full: tx_full_reg, rx_full: rx_full_reg};
  assign IRQ_O       = done_reg && IRQ_EN_I;
  assign SCK_O       = sck_reg;
  // R8: clock pin driven only as master
  assign SCK_OE_N_O  = !(PORT_EN_I && c.master_mode);
  assign SDO_O       = out_reg;
  // R19: output disable releases the data pin
  assign SDO_OE_N_O  = !(PORT_EN_I && !c.out_pin_disable && !sel_hold);
  assign SS_O        = fs_reg;
  assign SS_OE_N_O   = !(PORT_EN_I && gen_fs);

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_done_flag_sets:   // R2
    assert property (done_evt |=> done_reg && STAT_O.transfer_done_flag) else $error("done flag not set");
  a_irq_masked:       // R2
    assert property (!IRQ_EN_I |-> !IRQ_O) else $error("irq while disabled");
  a_rx_move:          // R3
    assert property (done_evt && !rx_full_reg |=> rx_full_reg && BUF_RDATA_O == $past(word_in))
      else $error("word not moved");
  a_ovf_drop:         // R4
    assert property (done_evt && rx_full_reg && !BUF_RD_I |=> ovf_reg && $stable(BUF_RDATA_O))
      else $error("overflow handling wrong");
  a_ovf_freeze:       // R5
    assert property (ovf_reg |-> !sample_edge && !shift_edge) else $error("edge taken in overflow");
  a_tx_load:          // R6
    assert property (load_evt |=> sr_reg == $past(tx_buf_reg) && !tx_full_reg || $past(BUF_WR_I))
      else $error("transmit word not loaded");
  a_master_start:     // R9
    assert property (start_ok && c.master_mode |=> state_reg != SSP_IDLE || $past(port_hold) == 1'h0 && port_hold)
      else $error("master did not start");
  a_bit_count:        // R1
    assert property ($rose(state_reg == SSP_DATA) && !c.framed_mode_enable |-> bit_cnt_reg == 5'h0)
      else $error("bit count not cleared");
  a_select_reset:     // R23
    assert property (sel_hold |=> state_reg == SSP_IDLE && bit_cnt_reg == 5'h0) else $error("select not reset");
  a_sdo_off:          // R12
    assert property (sel_hold || c.out_pin_disable |-> SDO_OE_N_O) else $error("data pin driven");
  a_width_reset:      // R17
    assert property (c.word_width_select != width_reg |=> state_reg == SSP_IDLE) else $error("width change no reset");
  a_sync_pulse:       // R22
    assert property ($rose(fs_reg) |-> state_reg == SSP_SYNC && $past(state_reg) == SSP_IDLE)
      else $error("sync pulse outside sync phase");

  c_master_word: cover property (done_evt && c.master_mode);
  c_slave_word:  cover property (done_evt && !c.master_mode);
  c_overflow:    cover property ($rose(ovf_reg));
  c_framed:      cover property (state_reg == SSP_SYNC ##[1:600] state_reg == SSP_DATA);
endmodule // ssp_core
`default_nettype wire

/* File: ssp_peer.sv */
// ssp_peer.sv: serial peer on the far side of the port, shifting on the shift clock pin
// assumes: the bench arms a word with a rising load before each frame whose received word it checks; it rearms itself after each word
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
  // shift clock and data pins
  input  wire logic        sck_i,
  input  wire logic        sdo_i,
  output logic             sdi_o,
  // clock mode and width, as set in the port
  input  wire logic        cpol_i,
  input  wire logic        cke_i,
  input  wire logic        w16_i,
  // word to send and word seen
  input  wire logic        load_i,
  input  wire logic [15:0] word_i,
  output logic [15:0]      rx_o
);
  int          cnt = 0;
  logic [15:0] sr  = 16'h0000;
  initial rx_o = 16'h0000;
  initial sdi_o = 1'b0;
  // restart the frame with the msb on the line
  always @(posedge load_i) begin
    cnt = 0;
    sr = word_i;
    sdi_o = w16_i ? word_i[15] : word_i[7];
  end
  // sample one edge, change the other
  always @(sck_i) begin
    if ((sck_i !== cpol_i) == cke_i) begin
      rx_o <= {rx_o[14:0], sdo_i};
      if (cnt == (w16_i ? 15 : 7)) begin
        // rearm only: a slave port latches the last bit after this edge
        cnt <= 0;
        sr <= word_i;
      end else
        cnt <= cnt + 1;
    end else
      sdi_o <= sr[(w16_i ? 15 : 7) - cnt];
  end
endmodule // ssp_peer
`default_nettype wire

/* File: spi_master_slave_port_test.sv */
// spi_master_slave_port_test.sv: self-checking bench of the serial port, master and slave
// assumes: ssp_pkg, ssp_core and ssp_peer compiled first; inputs change at the falling edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module spi_master_slave_port_test;
  import ssp_pkg::*;
  logic        clk, nrst, en, irq_en, wr, rd, ovf_clr, done_clr, tb_sck, ss, pload, ss_seen;
  logic        irq, sck_o, sck_oe_n, sdo, sdo_oe_n, sdi, ss_o, ss_oe_n;
  logic [15:0] wdata, rdata, pword, prx, m, a, p, x;
  logic [15:0] exp_q [$];
  ssp_ctrl_t   ctrl, c;
  ssp_stat_t   stat;
  int          fail_count, cmp_count, cyc, tog, hp, n, k, i;
  time         t0;
  // wire levels from each party's enable
  wire logic   sck_line = sck_oe_n ? tb_sck : sck_o;
  wire logic   ss_line  = ss_oe_n ? ss : ss_o;

  ssp_core dut_u (.CLK_I(clk), .NRST_I(nrst), .PORT_EN_I(en), .CTRL_I(ctrl), .IRQ_EN_I(irq_en),
    .BUF_WR_I(wr), .BUF_WDATA_I(wdata), .BUF_RD_I(rd), .OVF_CLR_I(ovf_clr), .DONE_CLR_I(done_clr),
    .BUF_RDATA_O(rdata), .STAT_O(stat), .IRQ_O(irq), .SCK_I(sck_line), .SCK_O(sck_o), .SCK_OE_N_O(sck_oe_n),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .SS_I(ss_line), .SS_O(ss_o), .SS_OE_N_O(ss_oe_n));
  ssp_peer peer_u (.sck_i(sck_line), .sdo_i(sdo), .sdi_o(sdi), .cpol_i(ctrl.clock_idle_polarity),
    .cke_i(ctrl.clock_edge_select), .w16_i(ctrl.word_width_select), .load_i(pload), .word_i(pword), .rx_o(prx));

  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cut a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_of_test();
    end
  end
  // shift clock toggles and the first half period
  always @(sck_o) begin
    if (tog == 1) hp = int'(($time - t0) / 8);
    t0 = $time;
    tog++;
  end
  always @(posedge ss_o) ss_seen = 1'b1;

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int t);
    repeat (t) @(negedge clk);
  endtask
  // half period model: primary 64/16/4/1, secondary 8 minus field
  function automatic int div(input ssp_ctrl_t x);
    int pf [4] = '{64, 16, 4, 1};
    return pf[x.primary_prescale] * (8 - x.secondary_prescale);
  endfunction
  // reconfigure with the port held off
  task automatic cfg(input ssp_ctrl_t x);
    en = 1'b0;
    tick(1);
    ctrl = x;
    tb_sck = x.clock_idle_polarity;
    tick(1);
    en = 1'b1;
    tick(3);
    m = x.word_width_select ? 16'hffff : 16'h00ff;
    n = x.word_width_select ? 16 : 8;
  endtask
  task automatic arm(input logic [15:0] w);
    pword = w;
    pload = 1'b1;
    tick(1);
    pload = 1'b0;
  endtask
  task automatic put(input logic [15:0] w);
    wdata = w;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  task automatic wait_done();
    for (k = 0; k < 4000 && stat.transfer_done_flag !== 1'b1; k++) tick(1);
  endtask
  // read the buffer and clear done and overflow in the same cycle
  task automatic ack();
    rd = 1'b1;
    done_clr = 1'b1;
    ovf_clr = 1'b1;
    tick(1);
    {rd, done_clr, ovf_clr} = 3'h0;
    tick(1);
    `CHK("rx_full", 1'b0, stat.rx_full)
    `CHK("done_flag", 1'b0, stat.transfer_done_flag)
    `CHK("ovf_flag", 1'b0, stat.rx_overflow_flag)
  endtask
  // model: oldest expected receive word against the buffer
  task automatic chk_rx(input string nm);
    x = exp_q.pop_front();
    `CHK(nm, x, rdata)
  endtask
  task automatic sclk(input int t);
    repeat (t) begin
      tb_sck = ~tb_sck;
      tick(4);
    end
  endtask

  initial begin
    {nrst, en, irq_en, wr, rd, ovf_clr, done_clr, tb_sck, pload, ss_seen} = '0;
    {ss, wdata, pword, ctrl} = {1'b1, 48'h0};
    void'($urandom(13));
    tick(16);
    nrst = 1'b1;
    tick(2);
    // master words over clock modes, widths and rates
    for (i = 0; i < 8; i++) begin
      c = '0;
      c.master_mode = 1'b1;
      c.clock_edge_select = i[0];
      c.clock_idle_polarity = i[1];
      c.word_width_select = 1'($urandom_range(1));
      c.primary_prescale = 2'($urandom_range(3, 2));
      c.secondary_prescale = 3'($urandom);
      irq_en = i[2];
      cfg(c);
      `CHK("sck_oe_n", 1'b0, sck_oe_n)
      `CHK("sck_idle", c.clock_idle_polarity, sck_o)
      a = 16'($urandom);
      p = 16'($urandom);
      exp_q.push_back(p & m);
      arm(p);
      tog = 0;
      put(a);
      wait_done();
      `CHK("irq", irq_en, irq)
      tick(div(c) + 8);
      `CHK("toggles", 2 * n, tog)
      `CHK("half_period", div(c), hp)
      chk_rx("rx_buf");
      `CHK("peer_rx", a & m, prx & m)
      ack();
    end
    // second word queued behind the first, buffer not read until the closing ack
    c = '0;
    c.master_mode = 1'b1;
    c.primary_prescale = 2'h2;
    c.secondary_prescale = 3'h6;
    cfg(c);
    arm(16'h00a5);
    exp_q.push_back(16'h00a5);
    pword = 16'h003c;
    put(16'h005a);
    tick(2);
    put(16'h00c3);
    tick(1);
    `CHK("tx_full", 1'b1, stat.tx_full)
    wait_done();
    chk_rx("rx_first");
    for (k = 0; k < 4000 && stat.rx_overflow_flag !== 1'b1; k++) tick(1);
    `CHK("overflow", 1'b1, stat.rx_overflow_flag)
    `CHK("rx_kept", 16'h00a5, rdata)
    `CHK("tx_loaded", 1'b0, stat.tx_full)
    tick(20);
    `CHK("peer_second", 16'h00c3, prx & m)
    ack();
    // receive only, then framed master with generated sync
    c.out_pin_disable = 1'b1;
    cfg(c);
    `CHK("sdo_off", 1'b1, sdo_oe_n)
    c.out_pin_disable = 1'b0;
    c.framed_mode_enable = 1'b1;
    cfg(c);
    `CHK("sync_out", 1'b0, ss_oe_n)
    `CHK("sdo_on", 1'b0, sdo_oe_n)
    tog = 0;
    ss_seen = 1'b0;
    put(16'($urandom));
    wait_done();
    tick(16);
    `CHK("frame_toggles", 2 * n + 2, tog)
    `CHK("sync_seen", 1'b1, ss_seen)
    ack();
    c.frame_sync_direction = 1'b1;
    cfg(c);
    `CHK("sync_in", 1'b1, ss_oe_n)
    // slave, 16-bit, select control
    c = '0;
    c.select_control_enable = 1'b1;
    c.clock_edge_select = 1'b1;
    c.word_width_select = 1'b1;
    cfg(c);
    `CHK("slave_sck", 1'b1, sck_oe_n)
    `CHK("desel_sdo", 1'b1, sdo_oe_n)
    a = 16'($urandom);
    p = 16'($urandom);
    put(a);
    arm(p);
    exp_q.push_back(p);
    ss = 1'b0;
    tick(2);
    `CHK("sel_sdo", 1'b0, sdo_oe_n)
    sclk(2 * n);
    `CHK("slave_done", 1'b1, stat.transfer_done_flag)
    chk_rx("slave_rx");
    `CHK("slave_peer", a, prx)
    ack();
    // deselect in mid word, then a whole word from the msb
    p = 16'($urandom);
    arm(16'($urandom));
    sclk(3);
    ss = 1'b1;
    sclk(1);
    arm(p);
    exp_q.push_back(p);
    ss = 1'b0;
    tick(2);
    sclk(2 * n);
    chk_rx("resync_rx");
    ack();
    end_of_test();
  end
endmodule // spi_master_slave_port_test
`default_nettype wire
